/* File: inc/mic_pkg.sv */
// package: register map, field positions and widths for the per-core interrupt gating block
package mic_pkg;
   // core and channel counts
   localparam int NUM_CORES = 3;
   localparam int NUM_CHANNELS = 8;
   localparam int NUM_MISC = 4;
   localparam int CORE_IDX_W = 2;
   // bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // per-core register block: base plus core stride
   localparam logic [7:0] CORE_STRIDE = 8'h20;
   localparam logic [7:0] CORE_BASE = 8'h00;
   // register offsets inside a core block
   localparam logic [4:0] OFS_RX_THRESHOLD_IRQ_ENABLE = 5'h00;
   localparam logic [4:0] OFS_TX_CHANNEL_IRQ_ENABLE = 5'h04;
   localparam logic [4:0] OFS_MISC_IRQ_ENABLE = 5'h08;
   localparam logic [4:0] OFS_RX_THRESHOLD_IRQ_STATUS = 5'h0C;
   // shared interrupt-summary registers, above the core blocks
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h60;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h64;
   // misc enable field positions
   localparam int MISC_USER_ACCESS_DONE_BIT = 0;
   localparam int MISC_LINK_CHANGE_BIT = 1;
   localparam int MISC_HOST_PENDING_BIT = 2;
   localparam int MISC_STATS_PENDING_BIT = 3;
   // reset values
   localparam logic [7:0] CHAN_EN_RESET = 8'h00;
   localparam logic [3:0] MISC_EN_RESET = 4'h0;
   // summary status layout: tx in bits 2-0, misc in 5-3, rx threshold in 8-6, one bit per core
   localparam int EVT_PER_CORE = 3;
   localparam int EVT_W = NUM_CORES * EVT_PER_CORE;
   localparam int EVT_TX = 0;
   localparam int EVT_MISC = 1;
   localparam int EVT_RXTH = 2;
   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/mic_core_gate.sv */
// one core's enable registers and the gating of its three interrupt groups
`timescale 1ns/1ps
module mic_core_gate (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_tx_en,
   input wire logic wr_misc_en,
   input wire logic wr_rxth_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] tx_src,
   input wire logic [3:0] misc_src,
   input wire logic [7:0] rxth_src,
   output logic [7:0] tx_enable,
   output logic [3:0] misc_enable,
   output logic [7:0] rxth_enable,
   output logic [7:0] rxth_status,
   output logic tx_pulse,
   output logic misc_pulse,
   output logic rxth_pulse
);
   logic [7:0] next_rxth_status; // masked receive-threshold view

   // enable registers, reset to all blocked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_enable <= mic_pkg::CHAN_EN_RESET;
         misc_enable <= mic_pkg::MISC_EN_RESET;
         rxth_enable <= mic_pkg::CHAN_EN_RESET;
      end else begin
         // only the low bits are kept; upper bits are reserved
         if (wr_tx_en) begin
            tx_enable <= wr_data;
         end
         if (wr_misc_en) begin
            misc_enable <= wr_data[3:0];
         end
         if (wr_rxth_en) begin
            rxth_enable <= wr_data;
         end
      end
   end

   // channel condition masked by its enable
   always_comb begin
      next_rxth_status = rxth_src & rxth_enable;
   end

   // registered pulses so the top outputs come from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxth_status <= 8'h00;
         tx_pulse <= 1'b0;
         misc_pulse <= 1'b0;
         rxth_pulse <= 1'b0;
      end else begin
         rxth_status <= next_rxth_status;
         // a cleared enable bit blocks its channel
         tx_pulse <= |(tx_src & tx_enable);
         // each misc source has its own gate bit
         misc_pulse <= (misc_src[mic_pkg::MISC_STATS_PENDING_BIT]
                        & misc_enable[mic_pkg::MISC_STATS_PENDING_BIT])
                     | (misc_src[mic_pkg::MISC_HOST_PENDING_BIT]
                        & misc_enable[mic_pkg::MISC_HOST_PENDING_BIT])
                     | (misc_src[mic_pkg::MISC_LINK_CHANGE_BIT]
                        & misc_enable[mic_pkg::MISC_LINK_CHANGE_BIT])
                     | (misc_src[mic_pkg::MISC_USER_ACCESS_DONE_BIT]
                        & misc_enable[mic_pkg::MISC_USER_ACCESS_DONE_BIT]);
         rxth_pulse <= |next_rxth_status;
      end
   end
endmodule

/* File: logic/mic_top.sv */
// per-core interrupt gating block with an axi4-lite register slave
// Overview of operation
// - three cores each own separate enable/status registers
// - transmit enable bit n gates channel n
// - cleared transmit bit blocks; bits 31-8 read zero
// - misc bit 3 gates statistics pending
// - misc bit 2 gates host error pending
// - misc bit 1 gates management link change
// - misc bit 0 gates user access done
// - threshold status is source masked by enable
// - status bit one when pulse conditions met
// - threshold enable bit n gates receive channel n
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mic_top (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt sources, same clock domain
   input wire logic [7:0] tx_done_src,
   input wire logic [7:0] rx_threshold_src,
   input wire logic stats_pending,
   input wire logic host_error_pending,
   input wire logic link_change_irq,
   input wire logic user_access_done_irq,
   // per-core pulses
   output logic [2:0] core_tx_pulse,
   output logic [2:0] core_misc_pulse,
   output logic [2:0] core_rx_threshold_pulse,
   // summary interrupt
   output logic irq
);
   localparam int NC = mic_pkg::NUM_CORES;
   localparam int EW = mic_pkg::EVT_W;

   logic [3:0] misc_src; // misc sources in enable-bit order
   logic [7:0] aw_addr; // latched write address
   logic aw_held; // write address taken
   logic [31:0] w_data; // latched write data
   logic [3:0] w_strb; // latched strobes
   logic w_held; // write data taken
   logic wr_fire; // both halves present, commit now
   logic wr_hit; // write address decodes
   logic [NC-1:0] wr_tx_en; // per-core write strobes
   logic [NC-1:0] wr_misc_en;
   logic [NC-1:0] wr_rxth_en;
   logic [7:0] tx_en_q [NC]; // per-core register views
   logic [3:0] misc_en_q [NC];
   logic [7:0] rxth_en_q [NC];
   logic [7:0] rxth_stat_q [NC];
   logic [NC-1:0] tx_p; // per-core pulses from gates
   logic [NC-1:0] misc_p;
   logic [NC-1:0] rxth_p;
   logic [EW-1:0] evt; // rising events this cycle
   logic [EW-1:0] evt_prev; // last pulse levels
   logic [EW-1:0] irq_status; // sticky event bits
   logic [EW-1:0] irq_mask; // one lets the bit raise irq
   logic [31:0] next_rdata; // read mux result
   logic next_rhit; // read address decodes

   assign misc_src = {stats_pending, host_error_pending, link_change_irq, user_access_done_irq};

   // one gate per core
   for (genvar c = 0; c < NC; c++) begin : g_core
      mic_core_gate u_gate (
         .aclk(aclk),
         .aresetn(aresetn),
         .wr_tx_en(wr_tx_en[c]),
         .wr_misc_en(wr_misc_en[c]),
         .wr_rxth_en(wr_rxth_en[c]),
         .wr_data(w_data[7:0]),
         .tx_src(tx_done_src),
         .misc_src(misc_src),
         .rxth_src(rx_threshold_src),
         .tx_enable(tx_en_q[c]),
         .misc_enable(misc_en_q[c]),
         .rxth_enable(rxth_en_q[c]),
         .rxth_status(rxth_stat_q[c]),
         .tx_pulse(tx_p[c]),
         .misc_pulse(misc_p[c]),
         .rxth_pulse(rxth_p[c])
      );
   end

   // pulses straight from the gate flops
   assign core_tx_pulse = tx_p;
   assign core_misc_pulse = misc_p;
   assign core_rx_threshold_pulse = rxth_p;

   // write channel capture: address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // ready only while that half is free and no response is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid
                          && !wr_fire;
         s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid
                         && !wr_fire;
      end
   end

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;

   // address decode for writes; only byte lane 0 carries enable bits
   always_comb begin
      wr_tx_en = '0;
      wr_misc_en = '0;
      wr_rxth_en = '0;
      wr_hit = 1'b0;
      for (int c = 0; c < NC; c++) begin
         if (aw_addr == mic_pkg::CORE_BASE + 8'(c) * mic_pkg::CORE_STRIDE
                        + 8'(mic_pkg::OFS_TX_CHANNEL_IRQ_ENABLE)) begin
            wr_hit = 1'b1;
            wr_tx_en[c] = wr_fire && w_strb[0];
         end
         if (aw_addr == mic_pkg::CORE_BASE + 8'(c) * mic_pkg::CORE_STRIDE
                        + 8'(mic_pkg::OFS_MISC_IRQ_ENABLE)) begin
            wr_hit = 1'b1;
            wr_misc_en[c] = wr_fire && w_strb[0];
         end
         if (aw_addr == mic_pkg::CORE_BASE + 8'(c) * mic_pkg::CORE_STRIDE
                        + 8'(mic_pkg::OFS_RX_THRESHOLD_IRQ_ENABLE)) begin
            wr_hit = 1'b1;
            wr_rxth_en[c] = wr_fire && w_strb[0];
         end
         // status register is read-only, writes ignored but answered okay
         if (aw_addr == mic_pkg::CORE_BASE + 8'(c) * mic_pkg::CORE_STRIDE
                        + 8'(mic_pkg::OFS_RX_THRESHOLD_IRQ_STATUS)) begin
            wr_hit = 1'b1;
         end
      end
      if (aw_addr == mic_pkg::OFS_IRQ_STATUS || aw_addr == mic_pkg::OFS_IRQ_MASK) begin
         wr_hit = 1'b1;
      end
   end

   // write response, slverr for unmapped addresses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= mic_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? mic_pkg::RESP_OKAY : mic_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // events are rising edges of each core's group pulses
   assign evt = {rxth_p, misc_p, tx_p} & ~evt_prev;

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_prev <= '0;
         irq_status <= '0;
         irq_mask <= '0;
      end else begin
         evt_prev <= {rxth_p, misc_p, tx_p};
         if (wr_fire && w_strb[0] && w_strb[1] && aw_addr == mic_pkg::OFS_IRQ_STATUS) begin
            irq_status <= (irq_status & ~w_data[EW-1:0]) | evt;
         end else begin
            irq_status <= irq_status | evt;
         end
         if (wr_fire && w_strb[0] && w_strb[1] && aw_addr == mic_pkg::OFS_IRQ_MASK) begin
            irq_mask <= w_data[EW-1:0];
         end
      end
   end

   // level interrupt from a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // read mux; reserved bits read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rhit = 1'b0;
      for (int c = 0; c < NC; c++) begin
         if (s_axi_araddr == mic_pkg::CORE_BASE + 8'(c) * mic_pkg::CORE_STRIDE
                             + 8'(mic_pkg::OFS_TX_CHANNEL_IRQ_ENABLE)) begin
            next_rhit = 1'b1;
            next_rdata = {24'h000000, tx_en_q[c]};
         end
         if (s_axi_araddr == mic_pkg::CORE_BASE + 8'(c) * mic_pkg::CORE_STRIDE
                             + 8'(mic_pkg::OFS_MISC_IRQ_ENABLE)) begin
            next_rhit = 1'b1;
            next_rdata = {28'h0000000, misc_en_q[c]};
         end
         if (s_axi_araddr == mic_pkg::CORE_BASE + 8'(c) * mic_pkg::CORE_STRIDE
                             + 8'(mic_pkg::OFS_RX_THRESHOLD_IRQ_ENABLE)) begin
            next_rhit = 1'b1;
            next_rdata = {24'h000000, rxth_en_q[c]};
         end
         if (s_axi_araddr == mic_pkg::CORE_BASE + 8'(c) * mic_pkg::CORE_STRIDE
                             + 8'(mic_pkg::OFS_RX_THRESHOLD_IRQ_STATUS)) begin
            next_rhit = 1'b1;
            next_rdata = {24'h000000, rxth_stat_q[c]};
         end
      end
      if (s_axi_araddr == mic_pkg::OFS_IRQ_STATUS) begin
         next_rhit = 1'b1;
         next_rdata = {23'h000000, irq_status};
      end
      if (s_axi_araddr == mic_pkg::OFS_IRQ_MASK) begin
         next_rhit = 1'b1;
         next_rdata = {23'h000000, irq_mask};
      end
   end

   // read channel: accept one address, answer next cycle, hold until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= mic_pkg::RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rhit ? mic_pkg::RESP_OKAY : mic_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else begin
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

/* File: verif/mic_core_model.sv */
// model of the three cores' interrupt inputs: counts pulse rising edges
`timescale 1ns/1ps
module mic_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [2:0] core_tx_pulse,
   input wire logic [2:0] core_misc_pulse,
   input wire logic [2:0] core_rx_threshold_pulse,
   output logic [15:0] rise_total
);
   logic [8:0] now_lvl; // all nine core inputs
   logic [8:0] prev_lvl; // levels one edge ago
   assign now_lvl = {core_tx_pulse, core_misc_pulse, core_rx_threshold_pulse};
   // a core sees one interrupt per rising edge, levels held do not recount
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_lvl <= 9'h000;
         rise_total <= 16'h0000;
      end else begin
         prev_lvl <= now_lvl;
         rise_total <= rise_total + 16'($countones(now_lvl & ~prev_lvl));
      end
   end
endmodule

/* File: verif/mic_top_sva.sv */
// assertion checker for the per-core interrupt gating block
`timescale 1ns/1ps
module mic_top_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] tx_done_src,
   input wire logic [7:0] rx_threshold_src,
   input wire logic stats_pending,
   input wire logic host_error_pending,
   input wire logic link_change_irq,
   input wire logic user_access_done_irq,
   input wire logic [2:0] core_tx_pulse,
   input wire logic [2:0] core_misc_pulse,
   input wire logic [2:0] core_rx_threshold_pulse
);
   // any misc source up, in one wire
   logic misc_any;
   assign misc_any = stats_pending | host_error_pending | link_change_irq | user_access_done_irq;
   // one clock domain, so one default clock and reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   tx_quiet_a: assert property ((tx_done_src == 8'h00) |=> (core_tx_pulse == 3'h0))
      else $error("tx pulse without a source");
   misc_quiet_a: assert property (!misc_any |=> (core_misc_pulse == 3'h0))
      else $error("misc pulse without a source");
   rx_quiet_a: assert property ((rx_threshold_src == 8'h00) |=> !(|core_rx_threshold_pulse))
      else $error("threshold pulse without a source");
   tx_cause_a: assert property ($rose(|core_tx_pulse) |-> $past(tx_done_src != 8'h00))
      else $error("tx pulse rose with no active channel");
   rd_upper_a: assert property (s_axi_rvalid |-> (s_axi_rdata[31:9] == 23'h0))
      else $error("reserved read bits not zero");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   // main scenarios reached
   wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
   misc_seen_c: cover property ($rose(|core_misc_pulse));
   rx_seen_c: cover property ($rose(|core_rx_threshold_pulse));
endmodule

bind mic_top mic_top_chk i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_done_src(tx_done_src),
   .rx_threshold_src(rx_threshold_src), .stats_pending(stats_pending),
   .host_error_pending(host_error_pending), .link_change_irq(link_change_irq),
   .user_access_done_irq(user_access_done_irq), .core_tx_pulse(core_tx_pulse),
   .core_misc_pulse(core_misc_pulse), .core_rx_threshold_pulse(core_rx_threshold_pulse));

/* File: verif/tb.sv */
// self-checking bench for the per-core interrupt gating block
`timescale 1ns/1ps
module tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic stats_pending, host_error_pending, link_change_irq, user_access_done_irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr, tx_done_src, rx_threshold_src;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [2:0] core_tx_pulse, core_misc_pulse, core_rx_threshold_pulse;
   logic [15:0] rise_total, base;
   int err_total = 0;
   int checked = 0;
   int stall = 0; // edges a slow master waits before taking an answer
   // per-core enable patterns; core 2 threshold pattern misses the source on purpose
   logic [7:0] txe [3] = '{8'h0F, 8'hF0, 8'h00};
   logic [7:0] rxe [3] = '{8'h0F, 8'hA5, 8'hC3};

   mic_top i_mic_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_done_src(tx_done_src),
      .rx_threshold_src(rx_threshold_src), .stats_pending(stats_pending),
      .host_error_pending(host_error_pending), .link_change_irq(link_change_irq),
      .user_access_done_irq(user_access_done_irq), .core_tx_pulse(core_tx_pulse),
      .core_misc_pulse(core_misc_pulse), .core_rx_threshold_pulse(core_rx_threshold_pulse),
      .irq(irq));
   mic_core_model i_mic_core_model (.aclk(aclk), .aresetn(aresetn),
      .core_tx_pulse(core_tx_pulse), .core_misc_pulse(core_misc_pulse),
      .core_rx_threshold_pulse(core_rx_threshold_pulse), .rise_total(rise_total));

   // 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // verdict and end of run, also reached by a timeout
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // byte address of a register in a core block
   function automatic logic [7:0] ra(input int c, input logic [4:0] o);
      return 8'(c) * mic_pkg::CORE_STRIDE + {3'h0, o};
   endfunction

   // let a source change reach the pulses, then sample off the edge
   task automatic step();
      repeat (3) @(posedge aclk);
      #1;
   endtask

   // axi4-lite write: both halves offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (stall == 0);
      for (int n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            return;
         end
         // a slow master lets the response wait a few edges
         if (aw_ok && w_ok && !s_axi_bready && n >= stall) begin
            s_axi_bready <= 1'b1;
         end
      end
      err_total++;
      close_out();
   endtask

   // axi4-lite read; rready held until the answer is sampled
   task automatic rd(input logic [7:0] a);
      logic ar_ok;
      ar_ok = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (stall == 0);
      for (int n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (!ar_ok && s_axi_arready) begin
            ar_ok = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            rdat = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            return;
         end
         // a slow master lets the read data wait a few edges
         if (ar_ok && !s_axi_rready && n >= stall) begin
            s_axi_rready <= 1'b1;
         end
      end
      err_total++;
      close_out();
   endtask

   // read and expect an okay answer with this value
   task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rdat, exp);
      chk(32'(resp), 32'(mic_pkg::RESP_OKAY));
   endtask

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      {tx_done_src, rx_threshold_src} = 16'h0000;
      {stats_pending, host_error_pending, link_change_irq, user_access_done_irq} = 4'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values of every core block and the summary pair
      for (int i = 0; i < 14; i++) begin
         rdx((i < 12) ? ra(i / 4, 5'(4 * (i % 4))) : 8'(8'h60 + 4 * (i - 12)), 32'h0);
      end
      rd(8'h10);
      chk(32'(resp), 32'(mic_pkg::RESP_SLVERR));
      chk(rdat, 32'h0);
      wr(8'h10, 32'h1);
      chk(32'(resp), 32'(mic_pkg::RESP_SLVERR));
      // lane 0 strobe off leaves the enables alone; answers taken late
      stall = 4;
      s_axi_wstrb <= 4'hE;
      wr(ra(2, mic_pkg::OFS_TX_CHANNEL_IRQ_ENABLE), 32'hFF);
      chk(32'(resp), 32'(mic_pkg::RESP_OKAY));
      rdx(ra(2, mic_pkg::OFS_TX_CHANNEL_IRQ_ENABLE), 32'h0);
      s_axi_wstrb <= 4'hF;
      stall = 0;
      $display("test reset map done");
      // transmit gating per channel, upper bits written but dropped
      for (int c = 0; c < 3; c++) begin
         wr(ra(c, mic_pkg::OFS_TX_CHANNEL_IRQ_ENABLE), {24'hFFFFFF, txe[c]});
         rdx(ra(c, mic_pkg::OFS_TX_CHANNEL_IRQ_ENABLE), {24'h0, txe[c]});
      end
      base = rise_total;
      for (int n = 0; n < 8; n++) begin
         @(posedge aclk);
         tx_done_src <= 8'(1 << n);
         step();
         chk(32'(core_tx_pulse), {29'h0, 1'b0, n > 3, n < 4});
         @(posedge aclk);
         tx_done_src <= 8'h00;
         step();
         chk(32'(core_tx_pulse), 32'h0);
      end
      chk(32'(rise_total - base), 32'h8);
      $display("test transmit gating done");
      // each misc enable bit against each misc source
      for (int b = 0; b < 4; b++) begin
         wr(ra(0, mic_pkg::OFS_MISC_IRQ_ENABLE), 32'(1 << b));
         wr(ra(1, mic_pkg::OFS_MISC_IRQ_ENABLE), 32'(~(1 << b) & 15));
         for (int s = 0; s < 4; s++) begin
            @(posedge aclk);
            {stats_pending, host_error_pending, link_change_irq, user_access_done_irq}
               <= 4'(1 << s);
            step();
            chk(32'(core_misc_pulse), {29'h0, 1'b0, s != b, s == b});
         end
         @(posedge aclk);
         {stats_pending, host_error_pending, link_change_irq, user_access_done_irq} <= 4'h0;
      end
      $display("test misc gating done");
      // threshold status is source masked by each core's enables
      for (int c = 0; c < 3; c++) begin
         wr(ra(c, mic_pkg::OFS_RX_THRESHOLD_IRQ_ENABLE), {24'h0, rxe[c]});
      end
      @(posedge aclk);
      rx_threshold_src <= 8'h3C;
      step();
      chk(32'(core_rx_threshold_pulse), 32'h3);
      wr(ra(0, mic_pkg::OFS_RX_THRESHOLD_IRQ_STATUS), 32'hFF);
      chk(32'(resp), 32'(mic_pkg::RESP_OKAY));
      for (int c = 0; c < 3; c++) begin
         rdx(ra(c, mic_pkg::OFS_RX_THRESHOLD_IRQ_STATUS), {24'h0, rxe[c] & 8'h3C});
      end
      @(posedge aclk);
      rx_threshold_src <= 8'h00;
      step();
      rdx(ra(1, mic_pkg::OFS_RX_THRESHOLD_IRQ_STATUS), 32'h0);
      $display("test threshold status done");
      // summary: clear, raise core 0 tx, mask, unmask, clear
      wr(8'h60, 32'h1FF);
      rdx(8'h60, 32'h0);
      wr(8'h64, 32'h1);
      @(posedge aclk);
      tx_done_src <= 8'h01;
      @(posedge aclk);
      tx_done_src <= 8'h00;
      step();
      rdx(8'h60, 32'h1);
      chk(32'(irq), 32'h1);
      wr(8'h64, 32'h0);
      step();
      chk(32'(irq), 32'h0);
      wr(8'h64, 32'h1);
      step();
      chk(32'(irq), 32'h1);
      wr(8'h60, 32'h1);
      step();
      chk(32'(irq), 32'h0);
      $display("test summary interrupt done");
      close_out();
   end
endmodule
